// ### hdl/flash_seq_cfg.svh
// Offsets, field positions, mode codes, keys and timing counts of the flash sequencer
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

`define CLK_HZ              10000000
`define ERASE_T0_US         3200
`define WRITE_T0_US         2200
`define ERASE_T1_US         3700
`define WRITE_T1_US         3000
`define US_CYCLES(us)       (((us) * (`CLK_HZ / 1000000)))
`define UNLOCK_TIMEOUT_CYC  256

`define OFS_CTRL_MAIN       8'h00
`define OFS_CTRL_TIMING     8'h04
`define OFS_ADDR_LOW        8'h08
`define OFS_ADDR_HIGH       8'h0C
`define OFS_DATA_LOW        8'h10
`define OFS_DATA_HIGH       8'h14
`define OFS_KEY1_LOW        8'h18
`define OFS_KEY1_HIGH       8'h1C
`define OFS_KEY2_LOW        8'h20
`define OFS_KEY2_HIGH       8'h24
`define OFS_KEY3_LOW        8'h28
`define OFS_KEY3_HIGH       8'h2C
`define OFS_STATUS          8'h30

// Main control register fields
`define MAIN_MODE_LSB       4
`define MAIN_ENABLED_BIT    3
`define MAIN_TRIGGER_BIT    2
`define MAIN_ARM_BIT        7
// Timing register fields
`define TIM_SELECT_BIT      1
`define TIM_CLEAR_BIT       0

`define MODE_WRITE          3'h0
`define MODE_ERASE          3'h1
`define MODE_UNLOCK         3'h6

`define KEY1_LOW            8'h00
`define KEY2_LOW            8'h0D
`define KEY3_LOW            8'hC3
`define KEY1_HIGH           8'h04
`define KEY2_HIGH           8'h09
`define KEY3_HIGH           8'h40

`define PAGE_WORDS          64
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// ### hdl/flash_seq_pkg.sv
// Types shared by the flash sequencer modules
package flash_seq_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_BUSY  = 2'b01,
        SEQ_CLEAR = 2'b11
    } seq_state_t;

    typedef logic [14:0] flash_addr_t;
    typedef logic [15:0] flash_word_t;
endpackage

// ### hdl/reg_write_if.sv
// Decoded register write strobe passed from the bus slave to the core
`timescale 1ns/100ps
interface reg_write_if;
    logic       wr_en;
    logic [7:0] wr_ofs;
    logic [7:0] wr_byte;
    modport source (output wr_en, output wr_ofs, output wr_byte);
    modport sink   (input wr_en, input wr_ofs, input wr_byte);
endinterface // reg_write_if

// ### hdl/axil_reg_slave.sv
// AXI4-Lite slave that turns bus writes into register strobes and serves reads
`timescale 1ns/100ps
`include "flash_seq_cfg.svh"
module axil_reg_slave
    import flash_seq_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic [7:0]       rd_ofs,
    input  wire logic [7:0]  rd_byte,
    input  wire logic        rd_hit,
    input  wire logic        stall,
    reg_write_if.source      wr
);
    logic       aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [7:0] aw_q, aw_d, wd_q, wd_d;
    logic       ws_q, ws_d;
    logic       bvalid_d, rvalid_d;
    logic [31:0] rdata_d;
    logic [1:0] bresp_d, rresp_d;
    logic       fire;

    function automatic logic ofs_mapped(input logic [7:0] a);
        ofs_mapped = (a[1:0] == 2'b00) && (a <= `OFS_STATUS);
    endfunction

    // Writes are held off while an erase or write runs, standing in for the halted processor
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        aw_d      = aw_q;
        wd_d      = wd_q;
        ws_d      = ws_q;
        bvalid_d  = bvalid;
        bresp_d   = bresp;
        fire      = aw_held_q && w_held_q && !bvalid && !stall;
        if (awvalid && awready) begin
            aw_held_d = 1'b1;
            aw_d      = awaddr;
        end
        if (wvalid && wready) begin
            w_held_d = 1'b1;
            wd_d     = wdata[7:0];
            ws_d     = wstrb[0];
        end
        if (fire) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = ofs_mapped(aw_q) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid_d = 1'b0;
        end
        rvalid_d = rvalid;
        rdata_d  = rdata;
        rresp_d  = rresp;
        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rdata_d  = {24'h00_0000, rd_byte};
            rresp_d  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid_d = 1'b0;
        end
    end

    assign awready  = !aw_held_q && aresetn;
    assign wready   = !w_held_q && aresetn;
    assign arready  = !rvalid && !stall && aresetn;
    assign rd_ofs   = araddr;
    assign wr.wr_en   = fire && ws_q && ofs_mapped(aw_q);
    assign wr.wr_ofs  = aw_q;
    assign wr.wr_byte = wd_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_q      <= 8'h00;
            wd_q      <= 8'h00;
            ws_q      <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= 2'b00;
            rvalid    <= 1'b0;
            rdata     <= 32'h0000_0000;
            rresp     <= 2'b00;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            aw_q      <= aw_d;
            wd_q      <= wd_d;
            ws_q      <= ws_d;
            bvalid    <= bvalid_d;
            bresp     <= bresp_d;
            rvalid    <= rvalid_d;
            rdata     <= rdata_d;
            rresp     <= rresp_d;
        end
    end
endmodule // axil_reg_slave

// ### hdl/page_buffer.sv
// 64-word page write buffer with a single write port and a clear
`timescale 1ns/100ps
`include "flash_seq_cfg.svh"
module page_buffer
    import flash_seq_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              wr_en,
    input  wire logic [5:0]        wr_idx,
    input  wire flash_word_t       wr_word,
    input  wire logic              clear,
    input  wire logic [5:0]        rd_idx,
    output flash_word_t            rd_word
);
    flash_word_t mem_q [`PAGE_WORDS];
    flash_word_t mem_d [`PAGE_WORDS];

    // Clear returns every word to zero, the erased state of the array
    always_comb begin
        for (int i = 0; i < `PAGE_WORDS; i++) begin
            mem_d[i] = clear ? 16'h0000 : mem_q[i];
        end
        if (wr_en && !clear) begin
            mem_d[wr_idx] = wr_word;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `PAGE_WORDS; g++) begin : g_word
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    mem_q[g] <= 16'h0000;
                end else begin
                    mem_q[g] <= mem_d[g];
                end
            end
        end
    endgenerate

    assign rd_word = mem_q[rd_idx];
endmodule // page_buffer

// ### hdl/flash_seq_top.sv
// Flash page erase/write sequencer: unlock, address tagging, page buffer and timed triggers
//
// Behaviour
// - A correct unlock sets the enabled flag; only then erase and write run.
// - In erase setup each high data write tags the address and increments it below the last word.
// - Address increment stops at the last word when the low six bits are all ones.
// - Mode 110 selects the unlock mode accepting the key sequence.
// - Arming in unlock mode starts a timeout timer for the key pattern.
// - Timer expiry clears the arm bit regardless of written keys.
// - Wrong key pattern leaves erase/write off; exact pattern enables it.
// - Software clearing the enabled flag disables erase/write at once.
// - A 64-word buffer maps onto the page chosen by address bits fourteen to six.
// - In write mode each low-then-high data write loads a word and advances the address up to the last word.
// - The buffer address saturates at the last page location.
// - Mode 001: buffer-clear empties the buffer, trigger erases the addressed page.
// - Mode 000 makes the trigger a page write.
// - Write trigger copies the buffer to flash; software polls the trigger low.
// - While an erase or write runs the processor is stalled.
// - The timing select bit chooses how long the trigger stays high.
// - High byte write loads the combined word; low byte write only stores.
// - Select zero: 3.2ms erase, 2.2ms write; one: 3.7ms erase, 3.0ms write.
// - Hardware clears the buffer-clear bit when clearing completes.
`timescale 1ns/100ps
`include "flash_seq_cfg.svh"
module flash_seq_top
    import flash_seq_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             cpu_stall,
    output logic             array_erase,
    output logic             array_write,
    output flash_addr_t      array_addr,
    output logic [63:0]      erase_tags,
    output flash_word_t      array_wdata
);
    localparam int ERASE0_CYC = `US_CYCLES(`ERASE_T0_US);
    localparam int WRITE0_CYC = `US_CYCLES(`WRITE_T0_US);
    localparam int ERASE1_CYC = `US_CYCLES(`ERASE_T1_US);
    localparam int WRITE1_CYC = `US_CYCLES(`WRITE_T1_US);

    reg_write_if wr ();

    logic [7:0]  rd_ofs, rd_byte;
    logic        rd_hit;
    logic [2:0]  mode_q, mode_d;
    logic        arm_q, arm_d, enabled_q, enabled_d;
    logic        trig_q, trig_d, tsel_q, tsel_d, clr_q, clr_d;
    flash_addr_t addr_q, addr_d;
    logic [7:0]  dlow_q, dlow_d;
    logic [7:0]  key_q [6];
    logic [7:0]  key_d [6];
    logic [63:0] tags_q, tags_d;
    logic [15:0] tmr_q, tmr_d;
    logic [8:0]  utmr_q, utmr_d;
    logic        op_erase_q, op_erase_d;
    logic [5:0]  widx_q, widx_d;
    seq_state_t  st_q, st_d;
    logic        buf_wr;
    flash_word_t buf_rd;
    logic        erase_pulse_d, write_pulse_d;
    flash_word_t wdata_d;
    logic        key_ok;

    axil_reg_slave u_slave (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awvalid (awvalid),
        .awready (awready),
        .awaddr  (awaddr),
        .wvalid  (wvalid),
        .wready  (wready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .bvalid  (bvalid),
        .bready  (bready),
        .bresp   (bresp),
        .arvalid (arvalid),
        .arready (arready),
        .araddr  (araddr),
        .rvalid  (rvalid),
        .rready  (rready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rd_ofs  (rd_ofs),
        .rd_byte (rd_byte),
        .rd_hit  (rd_hit),
        .stall   (cpu_stall),
        .wr      (wr.source)
    );

    page_buffer u_buf (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (buf_wr),
        .wr_idx  (addr_q[5:0]),
        .wr_word ({wr.wr_byte, dlow_q}),
        .clear   (st_q == SEQ_CLEAR),
        .rd_idx  (widx_q),
        .rd_word (buf_rd)
    );

    function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
        is_ofs = (a == o);
    endfunction

    assign key_ok = (key_q[0] == `KEY1_LOW) && (key_q[1] == `KEY1_HIGH) &&
                    (key_q[2] == `KEY2_LOW) && (key_q[3] == `KEY2_HIGH) &&
                    (key_q[4] == `KEY3_LOW) && (key_q[5] == `KEY3_HIGH);

    logic hi_wr;
    assign hi_wr  = wr.wr_en && is_ofs(wr.wr_ofs, `OFS_DATA_HIGH);
    assign buf_wr = hi_wr && (mode_q == `MODE_WRITE);

    // Read mux; reserved bits read as zero
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (rd_ofs)
            `OFS_CTRL_MAIN:   rd_byte = {arm_q, mode_q, enabled_q, trig_q, 2'b00};
            `OFS_CTRL_TIMING: rd_byte = {6'h00, tsel_q, clr_q};
            `OFS_ADDR_LOW:    rd_byte = addr_q[7:0];
            `OFS_ADDR_HIGH:   rd_byte = {1'b0, addr_q[14:8]};
            `OFS_DATA_LOW:    rd_byte = dlow_q;
            `OFS_DATA_HIGH:   rd_byte = 8'h00;
            `OFS_KEY1_LOW:    rd_byte = key_q[0];
            `OFS_KEY1_HIGH:   rd_byte = key_q[1];
            `OFS_KEY2_LOW:    rd_byte = key_q[2];
            `OFS_KEY2_HIGH:   rd_byte = key_q[3];
            `OFS_KEY3_LOW:    rd_byte = key_q[4];
            `OFS_KEY3_HIGH:   rd_byte = key_q[5];
            `OFS_STATUS:      rd_byte = {6'h00, cpu_stall, (st_q == SEQ_CLEAR)};
            default:          rd_hit  = 1'b0;
        endcase
    end

    always_comb begin
        mode_d        = mode_q;
        arm_d         = arm_q;
        enabled_d     = enabled_q;
        trig_d        = trig_q;
        tsel_d        = tsel_q;
        clr_d         = clr_q;
        addr_d        = addr_q;
        dlow_d        = dlow_q;
        key_d         = key_q;
        tags_d        = tags_q;
        tmr_d         = tmr_q;
        utmr_d        = utmr_q;
        op_erase_d    = op_erase_q;
        widx_d        = widx_q;
        st_d          = st_q;
        erase_pulse_d = 1'b0;
        write_pulse_d = 1'b0;
        wdata_d       = buf_rd;

        if (wr.wr_en) begin
            unique case (wr.wr_ofs)
                `OFS_CTRL_MAIN: begin
                    mode_d = wr.wr_byte[`MAIN_MODE_LSB +: 3];
                    // Clearing takes effect at once; setting is only by hardware
                    if (!wr.wr_byte[`MAIN_ENABLED_BIT]) begin
                        enabled_d = 1'b0;
                    end
                    if (wr.wr_byte[`MAIN_ARM_BIT] && !arm_q &&
                        wr.wr_byte[`MAIN_MODE_LSB +: 3] == `MODE_UNLOCK) begin
                        arm_d  = 1'b1;
                        utmr_d = 9'(`UNLOCK_TIMEOUT_CYC);
                    end
                    if (wr.wr_byte[`MAIN_TRIGGER_BIT] && st_q == SEQ_IDLE && enabled_q &&
                        (mode_q == `MODE_ERASE || mode_q == `MODE_WRITE)) begin
                        trig_d     = 1'b1;
                        op_erase_d = (mode_q == `MODE_ERASE);
                        tmr_d      = (mode_q == `MODE_ERASE) ?
                                     (tsel_q ? 16'(ERASE1_CYC) : 16'(ERASE0_CYC)) :
                                     (tsel_q ? 16'(WRITE1_CYC) : 16'(WRITE0_CYC));
                        widx_d     = 6'h00;
                        st_d       = SEQ_BUSY;
                    end
                end
                `OFS_CTRL_TIMING: begin
                    tsel_d = wr.wr_byte[`TIM_SELECT_BIT];
                    if (wr.wr_byte[`TIM_CLEAR_BIT] && st_q == SEQ_IDLE) begin
                        clr_d = 1'b1;
                        st_d  = SEQ_CLEAR;
                    end
                end
                `OFS_ADDR_LOW:  addr_d[7:0]  = wr.wr_byte;
                `OFS_ADDR_HIGH: addr_d[14:8] = wr.wr_byte[6:0];
                `OFS_DATA_LOW:  dlow_d = wr.wr_byte;
                `OFS_DATA_HIGH: begin
                    if (mode_q == `MODE_ERASE) begin
                        tags_d[addr_q[5:0]] = 1'b1;
                    end
                    if (addr_q[5:0] != 6'h3F) begin
                        addr_d = addr_q + 15'h0001;
                    end
                end
                default: begin
                    for (int k = 0; k < 6; k++) begin
                        if (wr.wr_ofs == 8'(`OFS_KEY1_LOW + 4 * k) && mode_q == `MODE_UNLOCK) begin
                            key_d[k] = wr.wr_byte;
                        end
                    end
                end
            endcase
        end

        // Unlock window: a matching pattern inside it enables, expiry disarms
        if (arm_q) begin
            if (key_ok) begin
                enabled_d = 1'b1;
                arm_d     = 1'b0;
                for (int k = 0; k < 6; k++) key_d[k] = 8'h00;
            end else if (utmr_q == 9'h000) begin
                arm_d = 1'b0;
            end else begin
                utmr_d = utmr_q - 9'h001;
            end
        end

        unique case (st_q)
            SEQ_IDLE: ;
            SEQ_CLEAR: begin
                clr_d  = 1'b0;
                st_d   = SEQ_IDLE;
            end
            SEQ_BUSY: begin
                if (op_erase_q) begin
                    erase_pulse_d = (tmr_q == 16'h0001);
                end else begin
                    write_pulse_d = !(widx_q == 6'h3F && array_addr[5:0] == 6'h3F);
                    if (widx_q != 6'h3F) widx_d = widx_q + 6'h01;
                end
                if (tmr_q == 16'h0001) begin
                    trig_d = 1'b0;
                    st_d   = SEQ_IDLE;
                    if (op_erase_q) tags_d = 64'h0;
                end else begin
                    tmr_d = tmr_q - 16'h0001;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= 3'h0; arm_q <= 1'b0; enabled_q <= 1'b0; trig_q <= 1'b0;
            tsel_q <= 1'b0; clr_q <= 1'b0; addr_q <= 15'h0000; dlow_q <= 8'h00;
            for (int k = 0; k < 6; k++) key_q[k] <= 8'h00;
            tags_q <= 64'h0; tmr_q <= 16'h0000; utmr_q <= 9'h000;
            op_erase_q <= 1'b0; widx_q <= 6'h00; st_q <= SEQ_IDLE;
            cpu_stall <= 1'b0; array_erase <= 1'b0; array_write <= 1'b0;
            array_addr <= 15'h0000; erase_tags <= 64'h0; array_wdata <= 16'h0000;
        end else begin
            mode_q <= mode_d; arm_q <= arm_d; enabled_q <= enabled_d; trig_q <= trig_d;
            tsel_q <= tsel_d; clr_q <= clr_d; addr_q <= addr_d; dlow_q <= dlow_d;
            key_q <= key_d; tags_q <= tags_d; tmr_q <= tmr_d; utmr_q <= utmr_d;
            op_erase_q <= op_erase_d; widx_q <= widx_d; st_q <= st_d;
            cpu_stall   <= (st_d == SEQ_BUSY);
            array_erase <= erase_pulse_d;
            array_write <= write_pulse_d;
            array_addr  <= {addr_q[14:6], widx_q};
            erase_tags  <= tags_q;
            array_wdata <= wdata_d;
        end
    end

    // Trigger time is counted here, being far too long for a delay range
    logic [15:0] op_len_q;
    always_ff @(posedge aclk) op_len_q <= (!aresetn || !trig_q) ? 16'h0000 : op_len_q + 16'h0001;
    property p_trig_needs_enable;
        @(posedge aclk) disable iff (!aresetn) $rose(trig_q) |-> $past(enabled_q);
    endproperty
    a_trig_needs_enable: assert property (p_trig_needs_enable) else $error("trigger w/o enable");
    property p_stall_follows_trig;
        @(posedge aclk) disable iff (!aresetn) $rose(trig_q) |-> ##1 cpu_stall;
    endproperty
    a_stall_follows_trig: assert property (p_stall_follows_trig) else $error("no stall");
    property p_addr_saturates;
        @(posedge aclk) disable iff (!aresetn)
            (hi_wr && addr_q[5:0] == 6'h3F) |=> (addr_q[5:0] == 6'h3F);
    endproperty
    a_addr_saturates: assert property (p_addr_saturates) else $error("address wrapped");
    property p_addr_incr;
        @(posedge aclk) disable iff (!aresetn)
            (hi_wr && addr_q[5:0] != 6'h3F) |=> (addr_q == $past(addr_q) + 15'h0001);
    endproperty
    a_addr_incr: assert property (p_addr_incr) else $error("address not advanced");
    property p_clear_done;
        @(posedge aclk) disable iff (!aresetn) $rose(clr_q) |=> !clr_q;
    endproperty
    a_clear_done: assert property (p_clear_done) else $error("clear stuck");

    property p_unlock_enable;
        @(posedge aclk) disable iff (!aresetn) (arm_q && key_ok) |=> enabled_q;
    endproperty
    a_unlock_enable: assert property (p_unlock_enable) else $error("unlock lost");

    property p_enable_cause;
        @(posedge aclk) disable iff (!aresetn) $rose(enabled_q) |-> $past(arm_q && key_ok);
    endproperty
    a_enable_cause: assert property (p_enable_cause) else $error("enable w/o key");

    property p_arm_timeout;
        @(posedge aclk) disable iff (!aresetn) (arm_q && utmr_q == 9'h000 && !key_ok) |=> !arm_q;
    endproperty
    a_arm_timeout: assert property (p_arm_timeout) else $error("arm not cleared");
    property p_op_len;
        @(posedge aclk) disable iff (!aresetn)
            $fell(trig_q) |-> op_len_q == (op_erase_q ? (tsel_q ? 16'(ERASE1_CYC) : 16'(ERASE0_CYC))
                : (tsel_q ? 16'(WRITE1_CYC) : 16'(WRITE0_CYC)));
    endproperty
    a_op_len: assert property (p_op_len) else $error("operation time wrong");
endmodule // flash_seq_top

// ### test/flash_seq_top_tb.sv
// Register-level bench for the flash erase/write sequencer
`timescale 1ns/100ps
`include "flash_seq_cfg.svh"
module flash_seq_top_tb;
    import flash_seq_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 4'h1;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, cpu_stall, array_erase, array_write;
    flash_addr_t array_addr;
    flash_word_t array_wdata, w62 = 0, w63 = 0;
    logic [63:0] erase_tags;
    int err_total = 0, comparisons = 0, stall_n = 0, erase_n = 0, write_n = 0, s0, i;
    logic [7:0] keys [6] = '{`KEY1_LOW, `KEY1_HIGH, `KEY2_LOW, `KEY2_HIGH, `KEY3_LOW, `KEY3_HIGH};
    flash_seq_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .cpu_stall(cpu_stall), .array_erase(array_erase), .array_write(array_write),
        .array_addr(array_addr), .erase_tags(erase_tags), .array_wdata(array_wdata));
    always #50 aclk = ~aclk;
    // Stall length is taken as a running total so each operation is measured by difference
    always @(posedge aclk) begin
        if (cpu_stall) stall_n <= stall_n + 1;
        if (array_erase) erase_n <= erase_n + 1;
        if (array_write && array_addr === 15'h013E) w62 <= array_wdata;
        if (array_write && array_addr === 15'h013F) w63 <= array_wdata;
        if (array_write) write_n <= write_n + 1;
    end
    task automatic report_and_stop;
        if (err_total == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        awaddr <= a; wdata <= {24'h00_0000, v}; awvalid <= 1; wvalid <= 1; bready <= 1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid && n < 50000);
        rs = bresp;
        bready <= 0;
        if (n >= 50000) begin err_total++; report_and_stop(); end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid && n < 50000);
        v = rdata;
        rready <= 0;
        if (n >= 50000) begin err_total++; report_and_stop(); end
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        rd(`OFS_CTRL_MAIN, d); chk(d, 0); chk(rresp, `RESP_OKAY);
        wr(`OFS_CTRL_MAIN, 8'h14, r); chk(r, `RESP_OKAY);
        // The status read lets the stall counter settle before it is compared
        rd(`OFS_STATUS, d); chk(d[1], 0); chk(stall_n, 0);
        // Wrong key, then let the arm window run out
        wr(`OFS_CTRL_MAIN, 8'hE0, r);
        for (i = 0; i < 6; i++) wr(8'(`OFS_KEY1_LOW + 4 * i), keys[i] ^ 8'h01, r);
        repeat (300) @(posedge aclk);
        rd(`OFS_CTRL_MAIN, d); chk(d[7:3], 5'b0_1100);
        wr(`OFS_CTRL_MAIN, 8'hE0, r);
        for (i = 0; i < 6; i++) wr(8'(`OFS_KEY1_LOW + 4 * i), keys[i], r);
        rd(`OFS_CTRL_MAIN, d); chk(d[3], 1);
        // Erase setup: tag from word 62, second and third tag writes must saturate
        wr(`OFS_CTRL_MAIN, 8'h18, r);
        wr(`OFS_ADDR_LOW, 8'h3E, r);
        wr(`OFS_ADDR_HIGH, 8'h01, r);
        for (i = 0; i < 3; i++) wr(`OFS_DATA_HIGH, 8'h00, r);
        wr(`OFS_CTRL_TIMING, 8'h01, r); rd(`OFS_CTRL_TIMING, d); chk(d[0], 0);
        chk(erase_tags, {2'b11, 62'h0});
        s0 = stall_n; wr(`OFS_CTRL_MAIN, 8'h1C, r);
        // The read is held off until the stall ends, so the counts below are final
        rd(`OFS_CTRL_MAIN, d); chk(d[2], 0);
        chk(erase_n, 1); chk(erase_tags, 64'h0);
        chk((stall_n - s0) inside {[32000:32004]}, 1);
        // Page write with long timing, words start at 61 and the fourth saturates at word 63
        wr(`OFS_CTRL_TIMING, 8'h02, r);
        wr(`OFS_CTRL_MAIN, 8'h08, r);
        wr(`OFS_ADDR_LOW, 8'h3D, r);
        for (i = 0; i < 4; i++) begin
            wr(`OFS_DATA_LOW, i[7:0], r);
            wr(`OFS_DATA_HIGH, 8'hA5, r);
        end
        s0 = stall_n; wr(`OFS_CTRL_MAIN, 8'h0C, r);
        rd(`OFS_CTRL_MAIN, d); chk(d[2], 0);
        chk((stall_n - s0) inside {[30000:30004]}, 1);
        chk(w62, 16'hA501);
        chk(w63, 16'hA503); chk(write_n, 64);
        // Rewrite one word without a fresh erase: clear the buffer, reload the address
        wr(`OFS_CTRL_TIMING, 8'h01, r);
        wr(`OFS_ADDR_LOW, 8'h3E, r);
        wr(`OFS_DATA_LOW, 8'h5A, r);
        wr(`OFS_DATA_HIGH, 8'h3C, r);
        s0 = stall_n; wr(`OFS_CTRL_MAIN, 8'h0C, r);
        rd(`OFS_CTRL_MAIN, d); chk(d[2], 0);
        chk((stall_n - s0) inside {[22000:22004]}, 1);
        chk(w62, 16'h3C5A); chk(w63, 16'h0000); chk(write_n, 128);
        // Software disable, then a trigger must be ignored
        wr(`OFS_CTRL_MAIN, 8'h10, r); rd(`OFS_CTRL_MAIN, d); chk(d[3], 0);
        s0 = stall_n; wr(`OFS_CTRL_MAIN, 8'h14, r);
        rd(`OFS_STATUS, d); chk(d[1], 0); chk(stall_n - s0, 0);
        wr(8'h40, 8'h00, r); chk(r, `RESP_SLVERR);
        report_and_stop();
    end
endmodule // flash_seq_top_tb
